// File: lcd_pkg.sv
/*
 * shared constants and carrier types of the lcd drive configuration block.
 * assumes a single 125 MHz core clock and an 8-bit host command bus.
 */
`default_nettype none
package lcd_pkg;
   // ------------------------------------------------------------
   // command codes, high seven bits; bit zero carries the value
   // ------------------------------------------------------------
   localparam logic [6:0] CMD_SEG_MAP = 7'h50;  // A0 / A1
   localparam logic [6:0] CMD_STATIC = 7'h52;   // A4 / A5
   localparam logic [6:0] CMD_DUTY = 7'h54;     // A8 / A9
   // ------------------------------------------------------------
   // geometry and field positions
   // ------------------------------------------------------------
   localparam int SEG_NUM = 80;                   // segment outputs
   localparam int ROW_NUM = 16;                   // master row outputs
   localparam logic [6:0] SEG_LAST = 7'h4F;       // column 79
   localparam logic [4:0] ROW_LAST_16 = 5'h0F;    // last row at 1/16 duty
   localparam logic [4:0] ROW_LAST_32 = 5'h1F;    // last row at 1/32 duty
   localparam int STAT_MAP_BIT = 6;               // mapping bit of status byte
   localparam int STAT_OFF_BIT = 5;               // display-off bit of status byte
   // ------------------------------------------------------------
   // timing and reset values
   // ------------------------------------------------------------
   localparam logic [3:0] LINE_CYCLES = 4'hF;     // line period minus one, in clocks
   localparam logic RST_SEG_INV = 1'b0;           // normal mapping
   localparam logic RST_STATIC = 1'b0;            // static drive off
   localparam logic RST_DUTY32 = 1'b0;            // 1/16 duty
   localparam int BUS_W = 11;                     // synchronised bus width
   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic seg_inv;    // segment order reversed
      logic static_on;  // static drive mode
      logic duty32;     // 1/32 duty selected
   } lcd_cfg_t;
   typedef struct packed {
      logic cd;         // command/data select, low for command
      logic rd_n;       // read strobe, active low
      logic wr_n;       // write strobe, active low
      logic [7:0] db;   // data bus
   } lcd_bus_t;
   typedef enum logic [1:0] {
      SCAN_RUN = 2'b01,  // scanning rows
      SCAN_HALT = 2'b10  // clocking frozen
   } lcd_scan_t;
endpackage
`default_nettype wire

// File: lcd_sync.sv
/*
 * two-flop synchroniser for a group of pin levels.
 * assumes the inputs are quasi-static relative to the clock.
 */
`timescale 1ns/100ps
`default_nettype none
module lcd_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;  // first stage, read only by the second
   logic [W-1:0] sync_q;  // second stage
   // ------------------------------------------------------------
   // two stages; reset value is all ones so strobes look idle
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end
   assign q_o = sync_q;
endmodule // lcd_sync
`default_nettype wire

// File: lcd_cfg.sv
/*
 * lcd drive configuration: decodes the mapping, static drive and duty
 * commands, scans rows, drives segments, and answers the status read.
 * assumes display-on and the current memory row come from same-clock logic.
 */
`timescale 1ns/100ps
`default_nettype none
module lcd_cfg (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire lcd_pkg::lcd_bus_t bus_i,
   input wire logic display_on_i,
   input wire logic [lcd_pkg::SEG_NUM-1:0] col_data_i,
   output logic [7:0] db_o,
   output logic db_oe_o,
   output logic [lcd_pkg::SEG_NUM-1:0] segment_outputs_o,
   output logic [lcd_pkg::ROW_NUM-1:0] master_row_outputs_o,
   output logic [4:0] scan_row_o,
   output logic oscillator_output_pin_o,
   output logic oscillator_output_pin_oe_o,
   output logic clk_run_o,
   output lcd_pkg::lcd_cfg_t cfg_o
);
   import lcd_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------
   lcd_bus_t bus_s;      // synchronised bus
   logic wr_n_prev_q;    // previous write strobe level
   logic wr_n_prev_d;
   lcd_sync #(.W(BUS_W)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(bus_i),
      .q_o(bus_s)
   );

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   logic cmd_wr;     // command write taken at rising edge of wr_n
   logic stat_rd;    // status read in progress
   logic blank;      // display off and static drive on
   lcd_cfg_t cfg_q;
   lcd_cfg_t cfg_d;
   // data latched at the end of the strobe, when it is surely settled
   assign cmd_wr = bus_s.wr_n && !wr_n_prev_q && !bus_s.cd && bus_s.rd_n;
   assign stat_rd = !bus_s.cd && !bus_s.rd_n && bus_s.wr_n;
   assign blank = !display_on_i && cfg_q.static_on;

   // next settings; unrelated codes leave them alone
   always_comb begin
      cfg_d = cfg_q;  // hold until rewritten
      wr_n_prev_d = bus_s.wr_n;
      if (cmd_wr) begin
         case (bus_s.db[7:1])
            CMD_SEG_MAP: cfg_d.seg_inv = bus_s.db[0];
            CMD_STATIC: cfg_d.static_on = bus_s.db[0];
            CMD_DUTY: cfg_d.duty32 = bus_s.db[0];
            default: cfg_d = cfg_q;  // other commands belong elsewhere
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_q <= '{seg_inv: RST_SEG_INV, static_on: RST_STATIC, duty32: RST_DUTY32};
         wr_n_prev_q <= 1'b1;
      end else begin
         cfg_q <= cfg_d;
         wr_n_prev_q <= wr_n_prev_d;
      end
   end

   // ------------------------------------------------------------
   // row scan and clock gating
   // ------------------------------------------------------------
   lcd_scan_t st_q;
   lcd_scan_t st_d;
   logic [3:0] line_q;   // cycles within a line
   logic [3:0] line_d;
   logic [4:0] row_q;    // current scan row
   logic [4:0] row_d;
   logic osc_q;          // oscillator pin level
   logic osc_d;
   logic line_tick;      // last cycle of a line
   logic [4:0] row_last; // last row for the duty in force
   assign line_tick = (line_q == LINE_CYCLES);
   assign row_last = cfg_q.duty32 ? ROW_LAST_32 : ROW_LAST_16;

   // scan sequencer; the halt state keeps every counter still
   always_comb begin
      st_d = st_q;
      line_d = line_q;
      row_d = row_q;
      osc_d = osc_q;
      case (st_q)
         SCAN_RUN: begin
            if (cfg_q.static_on) begin
               st_d = SCAN_HALT;
            end else begin
               line_d = line_tick ? 4'h0 : line_q + 4'h1;
               if (line_tick) begin
                  osc_d = !osc_q;
                  // a duty drop mid-frame can leave row past the end
                  row_d = (row_q >= row_last) ? 5'h00 : row_q + 5'h01;
               end
            end
         end
         SCAN_HALT: begin
            if (!cfg_q.static_on) begin
               st_d = SCAN_RUN;
            end
         end
         default: st_d = SCAN_RUN;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= SCAN_RUN;
         line_q <= 4'h0;
         row_q <= 5'h00;
         osc_q <= 1'b0;
      end else begin
         st_q <= st_d;
         line_q <= line_d;
         row_q <= row_d;
         osc_q <= osc_d;
      end
   end

   // ------------------------------------------------------------
   // output drive
   // ------------------------------------------------------------
   logic [SEG_NUM-1:0] seg_q;
   logic [SEG_NUM-1:0] seg_d;
   logic [ROW_NUM-1:0] com_q;
   logic [ROW_NUM-1:0] com_d;
   logic [7:0] db_q;
   logic [7:0] db_d;
   logic db_oe_q;
   logic db_oe_d;
   logic osc_oe_q;
   logic osc_oe_d;
   logic clk_run_q;
   logic clk_run_d;

   // segments, rows, status and pin enables
   always_comb begin
      seg_d = seg_q;
      com_d = com_q;
      if (blank) begin
         seg_d = '1;
         com_d = '1;
      end else if (!cfg_q.static_on) begin
         for (int i = 0; i < SEG_NUM; i++) begin
            // reversed order ascending order
            seg_d[i] = cfg_q.seg_inv ? col_data_i[SEG_NUM-1-i] : col_data_i[i];
         end
         if (!display_on_i) begin
            seg_d = '0;  // display off without static drive: no pixel on
         end
         // rows 16..31 belong to the slave, so the master goes quiet
         com_d = row_q[4] ? '0 : (ROW_NUM'(1) << row_q[3:0]);
      end
      db_d = 8'h00;
      db_d[STAT_MAP_BIT] = cfg_q.seg_inv;
      db_d[STAT_OFF_BIT] = !display_on_i;
      db_oe_d = stat_rd;
      osc_oe_d = !blank;
      clk_run_d = !cfg_q.static_on && !blank;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seg_q <= '0;
         com_q <= '0;
         db_q <= 8'h00;
         db_oe_q <= 1'b0;
         osc_oe_q <= 1'b1;
         clk_run_q <= 1'b1;
      end else begin
         seg_q <= seg_d;
         com_q <= com_d;
         db_q <= db_d;
         db_oe_q <= db_oe_d;
         osc_oe_q <= osc_oe_d;
         clk_run_q <= clk_run_d;
      end
   end

   assign segment_outputs_o = seg_q;
   assign master_row_outputs_o = com_q;
   assign db_o = db_q;
   assign db_oe_o = db_oe_q;
   assign scan_row_o = row_q;
   assign oscillator_output_pin_o = osc_q;
   assign oscillator_output_pin_oe_o = osc_oe_q;
   assign clk_run_o = clk_run_q;
   assign cfg_o = cfg_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_map_write: assert property (cmd_wr && bus_s.db[7:1] == CMD_SEG_MAP |=> cfg_q.seg_inv == $past(bus_s.db[0]))
      else $error("mapping write not applied");
   chk_static_write: assert property (cmd_wr && bus_s.db[7:1] == CMD_STATIC |=> cfg_q.static_on == $past(bus_s.db[0]))
      else $error("static write not applied");
   chk_duty_write: assert property (cmd_wr && bus_s.db[7:1] == CMD_DUTY |=> cfg_q.duty32 == $past(bus_s.db[0]))
      else $error("duty write not applied");
   chk_cfg_hold: assert property (!cmd_wr |=> $stable(cfg_q))
      else $error("setting changed without a write");
   chk_seg_invert: assert property (!blank && !cfg_q.static_on && display_on_i && cfg_q.seg_inv
      |=> seg_q[0] == $past(col_data_i[SEG_NUM-1]))
      else $error("inverted mapping wrong");
   chk_seg_normal: assert property (!blank && !cfg_q.static_on && display_on_i && !cfg_q.seg_inv
      |=> seg_q[0] == $past(col_data_i[0]))
      else $error("normal mapping wrong");
   chk_static_freeze: assert property (st_q == SCAN_HALT |=> $stable(row_q) && $stable(line_q))
      else $error("scan moved while frozen");
   chk_static_exit: assert property (st_q == SCAN_HALT && !cfg_q.static_on |=> st_q == SCAN_RUN ##1 clk_run_q || blank)
      else $error("static exit did not resume");
   chk_blank_high: assert property (blank ##1 blank |-> &seg_q && &com_q && !clk_run_q)
      else $error("blank outputs not high");
   chk_osc_float: assert property (blank |=> !osc_oe_q)
      else $error("oscillator pin still driven");
   chk_duty16_wrap: assert property (st_q == SCAN_RUN && !cfg_q.static_on && line_tick && !cfg_q.duty32
      && row_q == ROW_LAST_16 |=> row_q == 5'h00)
      else $error("1/16 scan did not wrap");
   chk_duty32_cont: assert property (st_q == SCAN_RUN && !cfg_q.static_on && line_tick && cfg_q.duty32
      && row_q == ROW_LAST_16 |=> row_q == 5'h10)
      else $error("1/32 scan stopped at 16");
   chk_master_rows: assert property (!blank && !cfg_q.static_on && row_q[4] |=> com_q == '0)
      else $error("master drove slave rows");
   chk_status_map: assert property (stat_rd |=> db_oe_q && db_q[STAT_MAP_BIT] == $past(cfg_q.seg_inv))
      else $error("status mapping bit wrong");

   cov_inv_map: cover property (cmd_wr && bus_s.db == 8'hA1);
   cov_static_blank: cover property (blank ##1 !blank);
   cov_duty32_frame: cover property (cfg_q.duty32 && row_q == ROW_LAST_32 && line_tick);
   cov_status_read: cover property (stat_rd ##1 db_oe_q);
endmodule // lcd_cfg
`default_nettype wire

// File: lcd_host_model.sv
/*
 * host model: drives the command/status pins of the lcd block.
 * assumes a free-running core clock and a bench that calls its tasks.
 */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// host bus driver
// ------------------------------------------------------------
module lcd_host_model (
   input wire logic ref_clk_i,
   input wire logic [7:0] db_i,
   input wire logic db_oe_i,
   output var lcd_pkg::lcd_bus_t bus_o,
   output var logic power_save_o
);
   import lcd_pkg::*;
   // idle: strobes high, data bus released
   initial begin
      bus_o = '{cd: 1'b0, rd_n: 1'b1, wr_n: 1'b1, db: 8'hFF};
      power_save_o = 1'b0;
   end
   // wait n edges, then step just past the edge
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   // one write; levels held 4 clocks, above the 3 the pins need
   task automatic write_cmd(input logic cd, input logic [7:0] code);
      hold(1);
      bus_o = '{cd: cd, rd_n: 1'b1, wr_n: 1'b0, db: code};
      hold(4);
      bus_o.wr_n = 1'b1;
      hold(6);
      bus_o.cd = 1'b0;
      bus_o.db = ~code; // released bus shows no stale value
   endtask
   // status read; answer sampled while the read levels stand
   task automatic read_status(output logic [7:0] st, output logic oe);
      hold(1);
      bus_o.rd_n = 1'b0;
      hold(5);
      st = db_i;
      oe = db_oe_i;
      bus_o.rd_n = 1'b1;
      hold(5);
   endtask
   // low power entry: static drive on (A5), then power_save_o raised
   task automatic enter_low_power();
      write_cmd(1'b0, 8'hA5);
      power_save_o = 1'b1;
   endtask
endmodule // lcd_host_model
`default_nettype wire

// File: lcd_drive_config_commands_bench.sv
/*
 * self-checking bench of the lcd configuration block.
 * assumes the host model drives the pins; display state is bench driven.
 */
`timescale 1ns/100ps
`default_nettype none
module lcd_drive_config_commands_bench;
   import lcd_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic display_on_i = 1'b1;
   logic [79:0] col;       // memory row shown to the block, follows the scan row
   logic [79:0] col_seen;  // the same row one clock late, as the registered outputs see it
   lcd_bus_t bus;
   logic [7:0] db;
   logic db_oe, osc, osc_oe, clk_run, psave;
   logic [79:0] seg;
   logic [15:0] rows;
   logic [4:0] row;
   lcd_cfg_t cfg;
   int n_mismatch = 0;
   int total_checks = 0;
   always #4 ref_clk_i = ~ref_clk_i; // 125 MHz
   // memory model: an asymmetric base pattern marked with the scan row number
   assign col = 80'h8000_0000_0000_0000_C3A5 ^ {16{row}};
   // segments are one clock behind the row data, so the expectation is too
   always @(posedge ref_clk_i) col_seen <= col;
   lcd_cfg u_lcd_cfg (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
      .display_on_i(display_on_i), .col_data_i(col), .db_o(db), .db_oe_o(db_oe),
      .segment_outputs_o(seg), .master_row_outputs_o(rows), .scan_row_o(row),
      .oscillator_output_pin_o(osc), .oscillator_output_pin_oe_o(osc_oe),
      .clk_run_o(clk_run), .cfg_o(cfg));
   lcd_host_model u_lcd_host_model (.ref_clk_i(ref_clk_i), .db_i(db),
      .db_oe_i(db_oe), .bus_o(bus), .power_save_o(psave));
   // ------------------------------------------------------------
   // checking helpers
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // column order reversed end for end, the inverted mapping expectation
   function automatic logic [79:0] flip(input logic [79:0] v);
      logic [79:0] r;
      for (int i = 0; i < 80; i++) r[i] = v[79-i];
      return r;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] c);
      u_lcd_host_model.write_cmd(1'b0, c);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // mapping: refused writes first, then inverted, status bit, normal
   task automatic t_mapping();
      logic [7:0] st;
      logic oe;
      check("reset cfg", 3'b000, cfg);
      u_lcd_host_model.write_cmd(1'b1, 8'hA1);
      wr(8'hA3);
      check("refused map", 1'b0, cfg.seg_inv);
      check("normal seg", col_seen, seg);
      wr(8'hA1);
      u_lcd_host_model.hold(2);
      check("inverted seg", flip(col_seen), seg);
      u_lcd_host_model.read_status(st, oe);
      check("status", 9'h140, {oe, st});
      wr(8'hA0);
      u_lcd_host_model.hold(2);
      check("back to normal", col_seen, seg);
      wr(8'hA1);
      check("map held", 1'b1, cfg.seg_inv);
   endtask
   // duty: 1/32 reaches row 31 with master rows idle, 1/16 tops out at 15
   task automatic t_duty();
      int i;
      logic [4:0] top;
      u_lcd_host_model.write_cmd(1'b0, 8'hA9);
      for (i = 0; i < 700 && row !== 5'h1F; i++) u_lcd_host_model.hold(1);
      check("row 31 seen", ROW_LAST_32, row);
      u_lcd_host_model.hold(2);
      check("master rows idle", 16'h0000, rows);
      wr(8'hA8);
      u_lcd_host_model.hold(40);
      top = 5'h00;
      for (i = 0; i < 600; i++) begin
         u_lcd_host_model.hold(1);
         if (row > top) top = row;
      end
      check("row top 1/16", ROW_LAST_16, top);
      for (i = 0; i < 300 && row !== 5'h05; i++) u_lcd_host_model.hold(1);
      u_lcd_host_model.hold(2);
      check("row 5 select", 16'h0020, rows);
   endtask
   // static drive: freeze, then display off state, then resume
   task automatic t_static();
      logic [4:0] held;
      logic [7:0] st;
      logic oe;
      logic o;
      u_lcd_host_model.enter_low_power();
      check("clk run", 1'b0, clk_run);
      check("power save", 1'b1, psave);
      held = row;
      o = osc;
      u_lcd_host_model.hold(64);
      check("row frozen", held, row);
      check("osc frozen", o, osc);
      display_on_i = 1'b0;
      u_lcd_host_model.hold(3);
      check("seg high", {80{1'b1}}, seg);
      check("rows high", 16'hFFFF, rows);
      check("osc floats", 1'b0, osc_oe);
      check("cfg kept", 3'b110, cfg);
      u_lcd_host_model.read_status(st, oe);
      check("status off", 9'h160, {oe, st});
      check("status released", 1'b0, db_oe);
      display_on_i = 1'b1;
      wr(8'hA4);
      held = row;
      u_lcd_host_model.hold(40);
      check("resumed", 1'b1, clk_run && (row !== held));
      check("osc driven", 1'b1, osc_oe);
      // a running scan flips the oscillator pin once per 16-clock line
      o = osc;
      u_lcd_host_model.hold(16);
      check("osc toggles", !o, osc);
   endtask
   // mid-run reset: settings fall back to reset values, writes work again
   task automatic t_reset();
      wr(8'hA9);
      check("cfg before reset", 3'b101, cfg);
      rst_n_i = 1'b0;
      u_lcd_host_model.hold(2);
      check("cfg in reset", 3'b000, cfg);
      rst_n_i = 1'b1;
      u_lcd_host_model.hold(2);
      check("cfg after reset", 3'b000, cfg);
      check("clk run after reset", 1'b1, clk_run);
      wr(8'hA1);
      check("write after reset", 3'b100, cfg);
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk_i);
      #1 rst_n_i = 1'b1;
      u_lcd_host_model.hold(4);
      check("osc oe reset", 1'b1, osc_oe);
      t_mapping();
      t_duty();
      t_static();
      t_reset();
      complete_run();
   end
   // run needs about 1550 clocks; 100 us leaves ample margin
   initial begin
      #100000;
      n_mismatch++;
      complete_run();
   end
endmodule // lcd_drive_config_commands_bench
`default_nettype wire
